// [design/svm_pkg.sv]
// constants and types shared by the supply monitor files
package svm_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [15:0] SVM_ADDR_THRESH = 16'hff04;
  localparam logic [15:0] SVM_ADDR_CTRL = 16'hff05;
  localparam logic [3:0] SVM_RESET_VAL = 4'h0;
  localparam int SVM_CODE_LSB = 0;
  localparam int SVM_CODE_MSB = 2;
  localparam int SVM_EN_BIT = 0;
  localparam int SVM_RES_BIT = 1;
  localparam logic [3:0] SVM_THRESH_MASK = 4'h7;

  // ****************************************
  // timing
  // ****************************************
  localparam int SVM_CLK_KHZ = 10000;
  localparam int SVM_SETTLE_US = 500;
  // least time, rounded up to whole cycles
  localparam int SVM_SETTLE_CYC = (SVM_SETTLE_US * SVM_CLK_KHZ + 999) / 1000;
  localparam int SVM_CNT_W = 16;

  // ****************************************
  // threshold levels in millivolts, index is the code
  // ****************************************
  localparam int SVM_MV_W = 12;
  localparam logic [SVM_MV_W-1:0] SVM_MV_OSC [8] = '{
    12'h73a, 12'h7d0, 12'h866, 12'h8fc, 12'h992, 12'ha28, 12'habe, 12'hb54};
  // code 0 has no level without the oscillator option
  localparam logic [SVM_MV_W-1:0] SVM_MV_NOOSC [8] = '{
    12'h000, 12'h46a, 12'h4c4, 12'h514, 12'h56e, 12'h5be, 12'h618, 12'h668};

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [15:0] addr;
    logic [3:0] wdata;
    logic wr;
    logic rd;
  } svm_bus_s;

  typedef enum logic [0:0] {
    SVM_OFF = 1'b0,
    SVM_ON = 1'b1
  } svm_state_e;

endpackage

// [design/svm_sync.sv]
// two-flop level synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module svm_sync (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // level in and out
  input wire logic async_in,
  output logic sync_out
);

  logic meta_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // svm_sync

// [design/svm_top.sv]
// supply monitor control: threshold select, enable and captured result
`timescale 1ns/1ps
// Operation
// - codes 0..7 pick 1.85..2.90 V levels
// - without oscillator option, codes 1..7 pick 1.13..1.64 V
// - detect only while enabled; enable reads back
// - enable falling captures result, monitor off
// - result 1 means below threshold; read-only
// - code at ff04 bits 2:0; ff05 bits 0,1
// - unused bits read zero, writes ignored
// - reset clears code, enable and result
module svm_top
  import svm_pkg::*;
#(
  parameter int SETTLE_CYCLES = SVM_SETTLE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // cpu i/o memory access
  input wire svm_bus_s bus,
  output logic [3:0] rdata_q,
  // analogue comparator side
  input wire logic below_threshold,
  input wire logic high_speed_oscillator_option,
  output logic monitor_on_q,
  output logic [2:0] threshold_code_q,
  output logic [SVM_MV_W-1:0] threshold_mv_q,
  output logic level_undefined_q,
  output logic settled_q
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic below_s;
  logic osc_opt_s;

  svm_sync u_sync_cmp (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(below_threshold),
    .sync_out(below_s)
  );

  svm_sync u_sync_opt (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(high_speed_oscillator_option),
    .sync_out(osc_opt_s)
  );

  // ****************************************
  // address decode
  // ****************************************
  logic wr_thresh;
  logic wr_ctrl;
  logic new_enable;
  svm_state_e state_q;
  logic result_q;
  logic [SVM_CNT_W-1:0] on_cnt_q;

  assign wr_thresh = bus.wr && (bus.addr == SVM_ADDR_THRESH);
  assign wr_ctrl = bus.wr && (bus.addr == SVM_ADDR_CTRL);
  assign new_enable = bus.wdata[SVM_EN_BIT];

  // ****************************************
  // threshold code register
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      threshold_code_q <= SVM_RESET_VAL[SVM_CODE_MSB:SVM_CODE_LSB];
    end else if (wr_thresh) begin
      threshold_code_q <= bus.wdata[SVM_CODE_MSB:SVM_CODE_LSB];
    end
  end

  // ****************************************
  // selected level, follows code and option strap
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      threshold_mv_q <= '0;
      level_undefined_q <= 1'b0;
    end else if (osc_opt_s) begin
      threshold_mv_q <= SVM_MV_OSC[threshold_code_q];
      level_undefined_q <= 1'b0;
    end else begin
      threshold_mv_q <= SVM_MV_NOOSC[threshold_code_q];
      level_undefined_q <= (threshold_code_q == 3'h0);
    end
  end

  // ****************************************
  // enable state, drives the comparator on
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= SVM_OFF;
    end else if (wr_ctrl) begin
      state_q <= new_enable ? SVM_ON : SVM_OFF;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      monitor_on_q <= 1'b0;
    end else if (wr_ctrl) begin
      monitor_on_q <= new_enable;
    end
  end

  // ****************************************
  // result latch
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      result_q <= 1'b0;
    end else begin
      unique case (state_q)
        SVM_OFF: begin
          result_q <= result_q;
        end
        SVM_ON: begin
          // capture only on the 1 to 0 write, hold otherwise
          if (wr_ctrl && !new_enable) begin
            result_q <= below_s;
          end
        end
      endcase
    end
  end

  // ****************************************
  // on-time counter, flags when comparator has settled
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      on_cnt_q <= '0;
    end else if (state_q == SVM_OFF) begin
      on_cnt_q <= '0;
    end else if (on_cnt_q != SVM_CNT_W'(SETTLE_CYCLES)) begin
      on_cnt_q <= on_cnt_q + SVM_CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      settled_q <= 1'b0;
    end else begin
      settled_q <= (state_q == SVM_ON) && (on_cnt_q == SVM_CNT_W'(SETTLE_CYCLES));
    end
  end

  // ****************************************
  // read data, one cycle after the read strobe
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= SVM_RESET_VAL;
    end else if (bus.rd) begin
      rdata_q <= '0;
      if (bus.addr == SVM_ADDR_THRESH) begin
        rdata_q[SVM_CODE_MSB:SVM_CODE_LSB] <= threshold_code_q;
      end else if (bus.addr == SVM_ADDR_CTRL) begin
        rdata_q[SVM_EN_BIT] <= monitor_on_q;
        rdata_q[SVM_RES_BIT] <= result_q;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  level_osc_map_a: assert property (@(posedge clk) disable iff (!reset_n)
    $past(osc_opt_s) && $past(threshold_code_q) == 3'h7 |-> threshold_mv_q == 12'hb54)
    else $error("code 7 with option not at top level");

  level_noosc_a: assert property (@(posedge clk) disable iff (!reset_n)
    $past(reset_n) && !$past(osc_opt_s)
    |-> level_undefined_q == ($past(threshold_code_q) == 3'h0))
    else $error("undefined level flag wrong without option");

  enable_readback_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_ctrl ##1 !wr_ctrl ##1 (bus.rd && bus.addr == SVM_ADDR_CTRL && !wr_ctrl)
    |=> rdata_q[SVM_EN_BIT] == $past(new_enable, 3))
    else $error("enable bit does not read back");

  capture_on_fall_a: assert property (@(posedge clk) disable iff (!reset_n)
    monitor_on_q && wr_ctrl && !new_enable |=> !monitor_on_q && result_q == $past(below_s))
    else $error("result not captured when monitor switched off");

  settle_count_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(settled_q) |-> $past(on_cnt_q) == SVM_CNT_W'(SETTLE_CYCLES))
    else $error("settled flag at wrong count");

  result_read_only_a: assert property (@(posedge clk) disable iff (!reset_n)
    !(monitor_on_q && wr_ctrl && !new_enable) |=> $stable(result_q))
    else $error("result changed without enable fall");

  unused_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.rd |=> rdata_q[3] == 1'b0 && (rdata_q[2] == 1'b0 || $past(bus.addr) == SVM_ADDR_THRESH))
    else $error("unused bit read as one");

  code_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_thresh |=> threshold_code_q == $past(bus.wdata[2:0]))
    else $error("threshold code not stored");

  hold_while_on_a: assert property (@(posedge clk) disable iff (!reset_n)
    (monitor_on_q && !wr_ctrl) [*2] |-> $stable(result_q))
    else $error("result moved while monitor enabled");

endmodule // svm_top

// [sim/test_supply_voltage_monitor.sv]
// self-checking testbench for the supply monitor control block
`timescale 1ns/1ps
module test_supply_voltage_monitor
  import svm_pkg::*;
;
  // ****************************************
  // signals
  // ****************************************
  localparam int SETTLE = 8;
  logic clk;
  logic reset_n;
  svm_bus_s bus;
  logic below_threshold;
  logic osc_opt;
  logic [3:0] rdata_q;
  logic monitor_on_q;
  logic [2:0] threshold_code_q;
  logic [SVM_MV_W-1:0] threshold_mv_q;
  logic level_undefined_q;
  logic settled_q;
  int mismatches;
  int comparisons;

  svm_top #(.SETTLE_CYCLES(SETTLE)) i_dut (
    .clk(clk),
    .reset_n(reset_n),
    .bus(bus),
    .rdata_q(rdata_q),
    .below_threshold(below_threshold),
    .high_speed_oscillator_option(osc_opt),
    .monitor_on_q(monitor_on_q),
    .threshold_code_q(threshold_code_q),
    .threshold_mv_q(threshold_mv_q),
    .level_undefined_q(level_undefined_q),
    .settled_q(settled_q)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ****************************************
  // bus and check tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [3:0] d);
    bus.addr = a;
    bus.wdata = d;
    bus.wr = 1'b1;
    tick(1);
    bus.wr = 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [15:0] a);
    bus.addr = a;
    bus.rd = 1'b1;
    tick(1);
    bus.rd = 1'b0;
    tick(1);
  endtask

  task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rd(SVM_ADDR_THRESH);
    chk("thresh reset", 12'(rdata_q), 12'h0);
    rd(SVM_ADDR_CTRL);
    chk("ctrl reset", 12'(rdata_q), 12'h0);
    chk("monitor reset", 12'(monitor_on_q), 12'h0);
  endtask

  task automatic t_codes(input logic opt);
    osc_opt = opt;
    tick(3);
    for (int i = 0; i < 8; i++) begin
      wr(SVM_ADDR_THRESH, 4'h8 | 4'(i));
      rd(SVM_ADDR_THRESH);
      chk("code read", 12'(rdata_q), 12'(i));
      chk("code out", 12'(threshold_code_q), 12'(i));
      chk("level", threshold_mv_q, opt ? SVM_MV_OSC[i] : SVM_MV_NOOSC[i]);
      chk("undefined", 12'(level_undefined_q), 12'(!opt && i == 0));
    end
  endtask

  task automatic t_capture;
    below_threshold = 1'b1;
    wr(SVM_ADDR_CTRL, 4'hf);
    chk("monitor on", 12'(monitor_on_q), 12'h1);
    rd(SVM_ADDR_CTRL);
    chk("enabled read", 12'(rdata_q), 12'h1);
    chk("not settled early", 12'(settled_q), 12'h0);
    // enable write was three cycles ago; flag rises SETTLE+1 cycles after it
    tick(SETTLE - 3);
    chk("not settled at count", 12'(settled_q), 12'h0);
    tick(1);
    chk("settled", 12'(settled_q), 12'h1);
    wr(SVM_ADDR_CTRL, 4'h0);
    chk("monitor off", 12'(monitor_on_q), 12'h0);
    rd(SVM_ADDR_CTRL);
    chk("low captured", 12'(rdata_q), 12'h2);
    below_threshold = 1'b0;
    wr(SVM_ADDR_CTRL, 4'h1);
    tick(SETTLE);
    chk("settled again", 12'(settled_q), 12'h1);
    rd(SVM_ADDR_CTRL);
    chk("held while on", 12'(rdata_q), 12'h3);
    wr(SVM_ADDR_CTRL, 4'h0);
    rd(SVM_ADDR_CTRL);
    chk("normal captured", 12'(rdata_q), 12'h0);
    below_threshold = 1'b1;
    tick(3);
    wr(SVM_ADDR_CTRL, 4'h2);
    rd(SVM_ADDR_CTRL);
    chk("no capture off", 12'(rdata_q), 12'h0);
  endtask

  task automatic t_midreset;
    below_threshold = 1'b1;
    wr(SVM_ADDR_THRESH, 4'h5);
    wr(SVM_ADDR_CTRL, 4'h1);
    tick(SETTLE + 1);
    wr(SVM_ADDR_CTRL, 4'h0);
    rd(SVM_ADDR_CTRL);
    chk("result before reset", 12'(rdata_q), 12'h2);
    wr(SVM_ADDR_CTRL, 4'h1);
    reset_n = 1'b0;
    tick(2);
    reset_n = 1'b1;
    tick(1);
    chk("code out after reset", 12'(threshold_code_q), 12'h0);
    chk("monitor after reset", 12'(monitor_on_q), 12'h0);
    chk("settled after reset", 12'(settled_q), 12'h0);
    rd(SVM_ADDR_CTRL);
    chk("ctrl after reset", 12'(rdata_q), 12'h0);
    rd(SVM_ADDR_THRESH);
    chk("thresh after reset", 12'(rdata_q), 12'h0);
  endtask

  task automatic t_unmapped;
    wr(16'hff06, 4'hf);
    rd(16'hff06);
    chk("unmapped read", 12'(rdata_q), 12'h0);
    rd(SVM_ADDR_THRESH);
    chk("thresh kept", 12'(rdata_q), 12'h7);
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    mismatches = 0;
    comparisons = 0;
    reset_n = 1'b0;
    bus = '0;
    below_threshold = 1'b0;
    osc_opt = 1'b1;
    repeat (16) @(posedge clk);
    #1;
    reset_n = 1'b1;
    tick(1);
    t_reset();
    t_codes(1'b1);
    t_codes(1'b0);
    t_capture();
    t_unmapped();
    t_midreset();
    summarize();
  end

  initial begin
    #2000000;
    mismatches++;
    summarize();
  end
endmodule // test_supply_voltage_monitor
